//--- inertial_output_registers.v
// Read-only output register bank for three rate and three acceleration axes.
`timescale 1ns/1ps
`include "inertial_consts.vh"

// Operation
// - rate word: signed, 0.1 deg/s per count
// - each rate axis has a fraction word
// - rate word over fraction forms 32-bit sample
// - x rate at 0x04 and 0x06, read-only
// - y rate at 0x08 and 0x0A, read-only
// - z rate at 0x0C and 0x0E, read-only
// - acceleration axes match the rotation axes
// - accel word over fraction forms 32-bit sample
// - accel word: signed, 1.25 mg per count
// - each accel axis has a fraction word
// - x accel at 0x10 and 0x12, read-only
// - y accel fraction at 0x14, read-only
// - y accel word at 0x16, read-only
// - z accel at 0x18 and 0x1A, read-only

// ****************************************************************
// Behaviour notes.
// ****************************************************************
// Each axis arrives as one 32-bit sample: the signed word in the upper half
// and the extra resolution bits in the lower half.
// Six samples travel together as one bundle, so all twelve output words
// always come from the same update.
// A two-entry buffer sits between the sampling path and the bank; the
// source is only stalled once both entries are full, so no bundle is lost.
// Reading a fraction word locks the bank until the word of the same pair is
// read; the host then sees both halves of one sample.
// Reading a word first takes no lock, so a host that only wants the coarse
// value never holds the bank.
// Hazard: a host that reads a fraction and never its word stalls every
// later update, and the sampling path then sees ready held low.
// A second fraction read moves the lock to the new pair.
// Both bytes of a word answer with the whole word, so odd addresses alias
// the even address below them.
// Reads outside the mapped window answer zero with the hit flag clear.
// Every read is answered exactly one cycle after its strobe.
// Writes are never decoded; the bank is filled by the sampling path only.
// After reset all words read zero until the first bundle is loaded.
// The buffer storage itself is not reset; only its pointers, count and ready are.
// The update pulse marks each load of the bank for one cycle.

module inertial_output_registers
#(
   parameter SAMPLE_WIDTH = 32,
   parameter ADDR_WIDTH   = 7
)
(
   // Clock and reset.
   input  wire                    clk,
   input  wire                    sys_rst,
   // Sample stream from the internal sampling path.
   input  wire                    sample_valid,
   output reg                     sample_ready,
   input  wire [SAMPLE_WIDTH-1:0] sample_rate_x,
   input  wire [SAMPLE_WIDTH-1:0] sample_rate_y,
   input  wire [SAMPLE_WIDTH-1:0] sample_rate_z,
   input  wire [SAMPLE_WIDTH-1:0] sample_accel_x,
   input  wire [SAMPLE_WIDTH-1:0] sample_accel_y,
   input  wire [SAMPLE_WIDTH-1:0] sample_accel_z,
   // Register access port from the serial interface logic.
   input  wire                    reg_read,
   input  wire                    reg_write,
   input  wire [ADDR_WIDTH-1:0]   reg_addr,
   output reg  [15:0]             reg_rdata,
   output reg                     reg_rvalid,
   output reg                     reg_hit,
   // Update and pairing status.
   output reg                     update_pulse,
   output reg                     pair_locked
);

   // ****************************************************************
   // Local sizes and pair selectors.
   // ****************************************************************
   localparam BUNDLE_WIDTH = 6 * SAMPLE_WIDTH;
   localparam [2:0] PAIR_NONE = 3'h7;

   // Returns the axis index 0..5 of a byte address, or PAIR_NONE.
   function [2:0] pair_of;
      input [ADDR_WIDTH-1:0] addr;
      reg   [ADDR_WIDTH-1:0] base;
      begin
         base = {addr[ADDR_WIDTH-1:2], 2'b00};
         case (base)
            `RATE_X_FRACTION_ADDR:  pair_of = 3'h0;
            `RATE_Y_FRACTION_ADDR:  pair_of = 3'h1;
            `RATE_Z_FRACTION_ADDR:  pair_of = 3'h2;
            `ACCEL_X_FRACTION_ADDR: pair_of = 3'h3;
            `ACCEL_Y_FRACTION_ADDR: pair_of = 3'h4;
            `ACCEL_Z_FRACTION_ADDR: pair_of = 3'h5;
            default:                pair_of = PAIR_NONE;
         endcase
      end
   endfunction

   // Returns true when a byte address names the fraction word of a pair.
   function is_fraction;
      input [ADDR_WIDTH-1:0] addr;
      begin
         is_fraction = (addr[1] == 1'b0);
      end
   endfunction

   // ****************************************************************
   // Two-entry buffer between the sampling path and the bank.
   // ****************************************************************
   // The occupancy count runs 0 to 2; ready is registered from the next
   // count, so it falls in the same edge that fills the second entry and
   // the buffer never accepts a bundle that would overflow it.
   reg  [BUNDLE_WIDTH-1:0] buf_mem [0:`BUFFER_DEPTH-1];
   reg                     buf_wr_ptr;
   reg                     buf_rd_ptr;
   reg  [1:0]              buf_count;
   reg  [1:0]              next_buf_count;
   wire                    buf_push;
   wire                    buf_pop;
   wire                    buf_out_valid;
   wire                    bank_ready;
   wire [BUNDLE_WIDTH-1:0] buf_in;
   wire [BUNDLE_WIDTH-1:0] buf_out;

   // Bundle the six axes; accel axes follow the rate axes' frame.
   assign buf_in = {sample_accel_z, sample_accel_y, sample_accel_x,
                    sample_rate_z, sample_rate_y, sample_rate_x};

   assign buf_push      = sample_valid & sample_ready;
   assign buf_out_valid = (buf_count != 2'd0);
   assign buf_pop       = buf_out_valid & bank_ready;
   assign buf_out       = buf_mem[buf_rd_ptr];

   // Occupancy after this cycle's push and pop.
   always @*
   begin
      next_buf_count = buf_count;
      if (buf_push & ~buf_pop)
      begin
         next_buf_count = buf_count + 2'd1;
      end
      else if (buf_pop & ~buf_push)
      begin
         next_buf_count = buf_count - 2'd1;
      end
   end

   // Pointers, occupancy and a registered ready that stalls the source.
   always @(posedge clk)
   begin
      if (sys_rst)
      begin
         buf_wr_ptr   <= 1'b0;
         buf_rd_ptr   <= 1'b0;
         buf_count    <= 2'd0;
         sample_ready <= 1'b0;
      end
      else
      begin
         if (buf_push)
         begin
            buf_wr_ptr <= ~buf_wr_ptr;
         end
         if (buf_pop)
         begin
            buf_rd_ptr <= ~buf_rd_ptr;
         end
         buf_count    <= next_buf_count;
         sample_ready <= (next_buf_count < 2'd2);
      end
   end

   // Storage for the buffered bundles.
   always @(posedge clk)
   begin
      if (buf_push)
      begin
         buf_mem[buf_wr_ptr] <= buf_in;
      end
   end

   // ****************************************************************
   // Pair lock: a fraction read holds the bank until its word is read.
   // ****************************************************************
   reg  [2:0] locked_pair;
   wire [2:0] read_pair;
   wire       read_fraction;
   wire       read_word;

   assign read_pair     = pair_of(reg_addr);
   assign read_fraction = reg_read & (read_pair != PAIR_NONE) & is_fraction(reg_addr);
   assign read_word     = reg_read & (read_pair != PAIR_NONE) & ~is_fraction(reg_addr);

   // Freezing the bank in the very cycle of a fraction read keeps a pop
   // from landing between the fraction read and the lock taking hold.
   // The bank takes a new update only while no pair is half read.
   assign bank_ready = ~pair_locked & ~read_fraction;

   // Lock on a fraction read; release on the matching word; another fraction moves the lock.
   always @(posedge clk)
   begin
      if (sys_rst)
      begin
         pair_locked <= 1'b0;
         locked_pair <= PAIR_NONE;
      end
      else if (read_fraction)
      begin
         pair_locked <= 1'b1;
         locked_pair <= read_pair;
      end
      else if (read_word & pair_locked & (read_pair == locked_pair))
      begin
         pair_locked <= 1'b0;
         locked_pair <= PAIR_NONE;
      end
   end

   // ****************************************************************
   // Output register bank: six pairs, word over fraction.
   // ****************************************************************
   reg [15:0] rate_x_fraction;
   reg [15:0] rate_x_word;
   reg [15:0] rate_y_fraction;
   reg [15:0] rate_y_word;
   reg [15:0] rate_z_fraction;
   reg [15:0] rate_z_word;
   reg [15:0] accel_x_fraction;
   reg [15:0] accel_x_word;
   reg [15:0] accel_y_fraction;
   reg [15:0] accel_y_word;
   reg [15:0] accel_z_fraction;
   reg [15:0] accel_z_word;

   // All twelve words load from one bundle in one edge.
   always @(posedge clk)
   begin
      if (sys_rst)
      begin
         rate_x_fraction  <= `OUTPUT_RESET_VALUE;
         rate_x_word      <= `OUTPUT_RESET_VALUE;
         rate_y_fraction  <= `OUTPUT_RESET_VALUE;
         rate_y_word      <= `OUTPUT_RESET_VALUE;
         rate_z_fraction  <= `OUTPUT_RESET_VALUE;
         rate_z_word      <= `OUTPUT_RESET_VALUE;
         accel_x_fraction <= `OUTPUT_RESET_VALUE;
         accel_x_word     <= `OUTPUT_RESET_VALUE;
         accel_y_fraction <= `OUTPUT_RESET_VALUE;
         accel_y_word     <= `OUTPUT_RESET_VALUE;
         accel_z_fraction <= `OUTPUT_RESET_VALUE;
         accel_z_word     <= `OUTPUT_RESET_VALUE;
         update_pulse     <= 1'b0;
      end
      else
      begin
         update_pulse <= buf_pop;
         if (buf_pop)
         begin
            // Upper half is the signed word, lower half the fraction.
            rate_x_word      <= buf_out[`BUNDLE_RATE_X_LSB+`SAMPLE_WORD_LSB +: 16];
            rate_x_fraction  <= buf_out[`BUNDLE_RATE_X_LSB+`SAMPLE_FRACTION_LSB +: 16];
            rate_y_word      <= buf_out[`BUNDLE_RATE_Y_LSB+`SAMPLE_WORD_LSB +: 16];
            rate_y_fraction  <= buf_out[`BUNDLE_RATE_Y_LSB+`SAMPLE_FRACTION_LSB +: 16];
            rate_z_word      <= buf_out[`BUNDLE_RATE_Z_LSB+`SAMPLE_WORD_LSB +: 16];
            rate_z_fraction  <= buf_out[`BUNDLE_RATE_Z_LSB+`SAMPLE_FRACTION_LSB +: 16];
            accel_x_word     <= buf_out[`BUNDLE_ACCEL_X_LSB+`SAMPLE_WORD_LSB +: 16];
            accel_x_fraction <= buf_out[`BUNDLE_ACCEL_X_LSB+`SAMPLE_FRACTION_LSB +: 16];
            accel_y_word     <= buf_out[`BUNDLE_ACCEL_Y_LSB+`SAMPLE_WORD_LSB +: 16];
            accel_y_fraction <= buf_out[`BUNDLE_ACCEL_Y_LSB+`SAMPLE_FRACTION_LSB +: 16];
            accel_z_word     <= buf_out[`BUNDLE_ACCEL_Z_LSB+`SAMPLE_WORD_LSB +: 16];
            accel_z_fraction <= buf_out[`BUNDLE_ACCEL_Z_LSB+`SAMPLE_FRACTION_LSB +: 16];
         end
      end
   end

   // ****************************************************************
   // Read decode: both bytes of a word answer with the whole word.
   // ****************************************************************
   reg [15:0]           next_rdata;
   reg                  next_hit;
   reg [ADDR_WIDTH-1:0] word_addr;

   // Writes are not decoded at all, so they change nothing.
   always @*
   begin
      word_addr  = {reg_addr[ADDR_WIDTH-1:1], 1'b0};
      next_hit   = 1'b1;
      next_rdata = `UNMAPPED_READ_VALUE;
      case (word_addr)
         `RATE_X_FRACTION_ADDR:  next_rdata = rate_x_fraction;
         `RATE_X_WORD_ADDR:      next_rdata = rate_x_word;
         `RATE_Y_FRACTION_ADDR:  next_rdata = rate_y_fraction;
         `RATE_Y_WORD_ADDR:      next_rdata = rate_y_word;
         `RATE_Z_FRACTION_ADDR:  next_rdata = rate_z_fraction;
         `RATE_Z_WORD_ADDR:      next_rdata = rate_z_word;
         `ACCEL_X_FRACTION_ADDR: next_rdata = accel_x_fraction;
         `ACCEL_X_WORD_ADDR:     next_rdata = accel_x_word;
         `ACCEL_Y_FRACTION_ADDR: next_rdata = accel_y_fraction;
         `ACCEL_Y_WORD_ADDR:     next_rdata = accel_y_word;
         `ACCEL_Z_FRACTION_ADDR: next_rdata = accel_z_fraction;
         `ACCEL_Z_WORD_ADDR:     next_rdata = accel_z_word;
         default:
         begin
            next_hit   = 1'b0;
            next_rdata = `UNMAPPED_READ_VALUE;
         end
      endcase
   end

   // Read answer registered one cycle after the strobe.
   always @(posedge clk)
   begin
      if (sys_rst)
      begin
         reg_rdata  <= `UNMAPPED_READ_VALUE;
         reg_rvalid <= 1'b0;
         reg_hit    <= 1'b0;
      end
      else
      begin
         reg_rvalid <= reg_read;
         if (reg_read)
         begin
            reg_rdata <= next_rdata;
            reg_hit   <= next_hit;
         end
      end
   end

   // ****************************************************************
   // Write strobe: accepted and ignored.
   // ****************************************************************
   // The bank is read-only: a write never reaches any register, and the
   // read path does not look at the write strobe, so a write in the same
   // cycle as a read cannot disturb the answer.
   wire write_dropped = reg_write;

endmodule // inertial_output_registers

//--- inertial_consts.vh
// Constants for the inertial output register bank.
`ifndef INERTIAL_CONSTS_VH
`define INERTIAL_CONSTS_VH

// ****************************************************************
// Register byte addresses (word-aligned, low byte of each word).
// ****************************************************************
`define RATE_X_FRACTION_ADDR  7'h04
`define RATE_X_WORD_ADDR      7'h06
`define RATE_Y_FRACTION_ADDR  7'h08
`define RATE_Y_WORD_ADDR      7'h0A
`define RATE_Z_FRACTION_ADDR  7'h0C
`define RATE_Z_WORD_ADDR      7'h0E
`define ACCEL_X_FRACTION_ADDR 7'h10
`define ACCEL_X_WORD_ADDR     7'h12
`define ACCEL_Y_FRACTION_ADDR 7'h14
`define ACCEL_Y_WORD_ADDR     7'h16
`define ACCEL_Z_FRACTION_ADDR 7'h18
`define ACCEL_Z_WORD_ADDR     7'h1A

// ****************************************************************
// Field layout of one 32-bit sample: word over fraction.
// ****************************************************************
`define SAMPLE_WORD_MSB       31
`define SAMPLE_WORD_LSB       16
`define SAMPLE_FRACTION_MSB   15
`define SAMPLE_FRACTION_LSB   0

// ****************************************************************
// Field layout of one bundle of six samples in the buffer.
// ****************************************************************
`define BUNDLE_RATE_X_LSB     0
`define BUNDLE_RATE_Y_LSB     32
`define BUNDLE_RATE_Z_LSB     64
`define BUNDLE_ACCEL_X_LSB    96
`define BUNDLE_ACCEL_Y_LSB    128
`define BUNDLE_ACCEL_Z_LSB    160

// ****************************************************************
// Reset values and the answer to an unmapped read.
// ****************************************************************
`define OUTPUT_RESET_VALUE    16'h0000
`define UNMAPPED_READ_VALUE   16'h0000
`define BUFFER_DEPTH          2

`endif

//--- inertial_output_registers_props.sv
// Concurrent checks on the ports of the output register bank.
`timescale 1ns/1ps
module inertial_props
#(
   parameter SAMPLE_WIDTH = 32,
   parameter ADDR_WIDTH   = 7
)
(
   // Clock and reset.
   input wire                  clk,
   input wire                  sys_rst,
   // Register port and status.
   input wire                  reg_read,
   input wire [ADDR_WIDTH-1:0] reg_addr,
   input wire [15:0]           reg_rdata,
   input wire                  reg_rvalid,
   input wire                  reg_hit,
   input wire                  sample_ready,
   input wire                  update_pulse,
   input wire                  pair_locked
);
   // Decode of the mapped window and of fraction addresses.
   wire mapped = (reg_addr >= 7'h04) && (reg_addr <= 7'h1B);
   wire frac   = mapped && !reg_addr[1];
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   chk_read_answer: assert property (reg_read |=> reg_rvalid)
      else $error("read strobe got no answer");
   chk_no_spurious: assert property (!reg_read |=> !reg_rvalid)
      else $error("answer without read strobe");
   chk_unmapped_zero: assert property (reg_read && !mapped |=> reg_rdata == 16'h0000 && !reg_hit)
      else $error("unmapped read not zero");
   chk_mapped_hit: assert property (reg_read && mapped |=> reg_hit)
      else $error("mapped read without hit");
   chk_data_holds: assert property (!reg_read |=> $stable(reg_rdata) && $stable(reg_hit))
      else $error("read data moved without read");
   chk_lock_set: assert property (reg_read && frac |=> pair_locked)
      else $error("fraction read did not lock");
   chk_word_nolock: assert property (reg_read && mapped && reg_addr[1] && !pair_locked |=> !pair_locked)
      else $error("word read locked a pair");
   chk_frozen_bank: assert property (pair_locked [*3] |-> !update_pulse)
      else $error("bank updated while locked");
   chk_ready_release: assert property ($past(sys_rst) && !sys_rst |=> sample_ready)
      else $error("buffer not ready after reset");
endmodule // inertial_props

bind inertial_output_registers inertial_props #(.SAMPLE_WIDTH(SAMPLE_WIDTH), .ADDR_WIDTH(ADDR_WIDTH)) u_props
   (.clk(clk), .sys_rst(sys_rst), .reg_read(reg_read), .reg_addr(reg_addr), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .reg_hit(reg_hit), .sample_ready(sample_ready), .update_pulse(update_pulse),
    .pair_locked(pair_locked));

//--- sample_source.sv
// Model of the sampling path that offers bundles of six samples.
`timescale 1ns/1ps
module sample_source
(
   // Clock and reset.
   input  wire         clk,
   input  wire         sys_rst,
   // Bundles queued by the bench.
   input  wire         push,
   input  wire [191:0] push_data,
   // Stream towards the bank.
   input  wire         sample_ready,
   output logic        sample_valid,
   output logic [191:0] sample_data
);
   logic [191:0] q [$];
   // A bundle stays offered until taken; idle data toggles each cycle between the last bundle and its inverse.
   always @(posedge clk)
   begin
      if (sys_rst)
         q.delete();
      else
      begin
         if (sample_valid && sample_ready)
            q.pop_front();
         if (push)
            q.push_back(push_data);
      end
      sample_valid <= (q.size() > 0);
      sample_data  <= (q.size() > 0) ? q[0] : ~sample_data;
   end
endmodule // sample_source

//--- testbench.sv
// Self-checking bench for the output register bank.
`timescale 1ns/1ps
`include "inertial_consts.vh"
module testbench;
   typedef struct packed {logic [6:0] a; logic [15:0] d; logic h;} row_t;
   logic clk, sys_rst, push, reg_read, reg_write, sample_valid, sample_ready;
   logic [191:0] push_data, sample_data;
   logic [6:0] reg_addr;
   logic [15:0] reg_rdata;
   logic reg_rvalid, reg_hit, update_pulse, pair_locked;
   int miscompares, compares, upd_cnt, i;
   row_t rows [0:14] = '{'{7'h04, 16'h0001, 1}, '{7'h06, 16'h4E20, 1}, '{7'h09, 16'h8000, 1},
      '{7'h0A, 16'hB1E0, 1}, '{7'h0C, 16'h0002, 1}, '{7'h0F, 16'hFFFF, 1}, '{7'h10, 16'h1234, 1},
      '{7'h12, 16'h7D00, 1}, '{7'h14, 16'h5678, 1}, '{7'h16, 16'h8300, 1}, '{7'h18, 16'h9ABC, 1},
      '{7'h1A, 16'h0001, 1}, '{7'h02, 16'h0000, 0}, '{7'h1C, 16'h0000, 0}, '{7'h7F, 16'h0000, 0}};

   sample_source u_src (.clk(clk), .sys_rst(sys_rst), .push(push), .push_data(push_data),
      .sample_ready(sample_ready), .sample_valid(sample_valid), .sample_data(sample_data));
   inertial_output_registers u_dut (.clk(clk), .sys_rst(sys_rst), .sample_valid(sample_valid),
      .sample_ready(sample_ready), .sample_rate_x(sample_data[31:0]), .sample_rate_y(sample_data[63:32]),
      .sample_rate_z(sample_data[95:64]), .sample_accel_x(sample_data[127:96]),
      .sample_accel_y(sample_data[159:128]), .sample_accel_z(sample_data[191:160]), .reg_read(reg_read),
      .reg_write(reg_write), .reg_addr(reg_addr), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
      .reg_hit(reg_hit), .update_pulse(update_pulse), .pair_locked(pair_locked));

   // Clock of 25 ns period.
   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   // Counts bank updates since the last reset.
   always @(posedge clk)
      upd_cnt <= sys_rst ? 0 : upd_cnt + (update_pulse === 1'b1);

   // Reports a mismatch between seen and expected values.
   task check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("unexpected %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // Prints the verdict and ends the run.
   task summarize;
      if (miscompares == 0 && compares > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // One word read with its answer checked a cycle later.
   task rd(input logic [6:0] a, input logic [15:0] d, input logic h);
      @(posedge clk);
      reg_read <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_read <= 1'b0;
      #1;
      check("rvalid", reg_rvalid, 16'h0001);
      check("rdata", reg_rdata, d);
      check("hit", reg_hit, h);
   endtask

   // Queues one bundle at the source.
   task put(input logic [191:0] b);
      @(posedge clk);
      push <= 1'b1;
      push_data <= b;
      @(posedge clk);
      push <= 1'b0;
   endtask

   // Bounded wait for a given number of bank updates.
   task wait_upd(input int n);
      for (i = 0; i < 60 && upd_cnt < n; i++)
         @(posedge clk);
      if (upd_cnt < n)
      begin
         miscompares++;
         summarize();
      end
   endtask

   // Main sequence: reset, table of reads, write, lock stall, second reset.
   initial
   begin
      {sys_rst, push, reg_read, reg_write} = 4'h8;
      push_data = '0;
      reg_addr = 7'h00;
      repeat (16) @(posedge clk);
      sys_rst <= 1'b0;
      rd(`RATE_X_WORD_ADDR, `OUTPUT_RESET_VALUE, 1'b1);
      put({32'h00019ABC, 32'h83005678, 32'h7D001234, 32'hFFFF0002, 32'hB1E08000, 32'h4E200001});
      wait_upd(1);
      foreach (rows[k])
         rd(rows[k].a, rows[k].d, rows[k].h);
      @(posedge clk);
      reg_write <= 1'b1;
      reg_addr <= `RATE_X_WORD_ADDR;
      @(posedge clk);
      reg_write <= 1'b0;
      rd(`RATE_X_WORD_ADDR, 16'h4E20, 1'b1);
      rd(`RATE_X_FRACTION_ADDR, 16'h0001, 1'b1);
      check("locked", pair_locked, 16'h0001);
      put({6{32'hA0015001}});
      put({6{32'hA0025002}});
      put({6{32'hA0035003}});
      repeat (6) @(posedge clk);
      check("ready", sample_ready, 16'h0000);
      check("updates", upd_cnt, 16'h0001);
      rd(`RATE_X_WORD_ADDR, 16'h4E20, 1'b1);
      wait_upd(4);
      repeat (4) @(posedge clk);
      check("updates", upd_cnt, 16'h0004);
      rd(`ACCEL_Z_WORD_ADDR, 16'hA003, 1'b1);
      rd(`ACCEL_Z_FRACTION_ADDR, 16'h5003, 1'b1);
      check("locked", pair_locked, 16'h0001);
      @(posedge clk);
      sys_rst <= 1'b1;
      repeat (2) @(posedge clk);
      sys_rst <= 1'b0;
      #1;
      check("ready", sample_ready, 16'h0000);
      check("locked", pair_locked, 16'h0000);
      check("hit", reg_hit, 16'h0000);
      rd(`ACCEL_Y_FRACTION_ADDR, `OUTPUT_RESET_VALUE, 1'b1);
      summarize();
   end
endmodule // testbench
